// ### include/cadc_pkg.sv
// Constants for the comparator and converter control block
package cadc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] CADC_ADDR_CMP_CTRL = 8'h00;
  localparam logic [7:0] CADC_ADDR_CHAN_SEL = 8'h04;
  localparam logic [7:0] CADC_ADDR_CONV_CTRL = 8'h08;
  localparam logic [7:0] CADC_ADDR_RES_LOW = 8'h0C;
  localparam logic [7:0] CADC_ADDR_RES_HIGH = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator control and status fields
  localparam int CADC_CMP_DISABLE_BIT = 7;
  localparam int CADC_CMP_BANDGAP_BIT = 6;
  localparam int CADC_CMP_OUTPUT_BIT = 5;
  localparam int CADC_CMP_FLAG_BIT = 4;
  localparam int CADC_CMP_IRQ_EN_BIT = 3;
  localparam int CADC_CMP_MUX_EN_BIT = 2;
  localparam int CADC_CMP_MODE_HI_BIT = 1;
  localparam int CADC_CMP_MODE_LO_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Channel select fields
  localparam int CADC_CHAN_REF_HI_BIT = 7;
  localparam int CADC_CHAN_REF_LO_BIT = 6;
  localparam int CADC_CHAN_LEFT_BIT = 5;
  localparam int CADC_CHAN_TOP_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Converter control and status fields
  localparam int CADC_CONV_ENABLE_BIT = 7;
  localparam int CADC_CONV_START_BIT = 6;
  localparam int CADC_CONV_FREE_BIT = 5;
  localparam int CADC_CONV_DONE_BIT = 4;
  localparam int CADC_CONV_IRQ_EN_BIT = 3;
  localparam int CADC_CONV_PS_HI_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0] CADC_CMP_CTRL_RESET = 8'h00;
  localparam logic [7:0] CADC_CHAN_SEL_RESET = 8'h00;
  localparam logic [7:0] CADC_CONV_CTRL_RESET = 8'h00;
  localparam logic [4:0] CADC_NORMAL_CYCLES = 5'h0D;
  localparam logic [4:0] CADC_EXTENDED_CYCLES = 5'h19;
  localparam logic [8:0] CADC_PRESCALE_BASE = 9'h002;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator interrupt modes
  typedef enum logic [1:0] {
    CADC_MODE_TOGGLE = 2'b00,
    CADC_MODE_RESERVED = 2'b01,
    CADC_MODE_FALL = 2'b10,
    CADC_MODE_RISE = 2'b11
  } cadc_mode_type;

  // Converter states
  typedef enum logic [0:0] {
    CADC_IDLE = 1'b0,
    CADC_RUN = 1'b1
  } cadc_state_type;

endpackage

// ### testbench/cadc_sva.sv
// Assertion checker for the comparator and converter control block
`timescale 1ns/10ps
module cadc_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic global_irq_enable_i,
  input wire logic comp_irq_o,
  input wire logic conv_irq_o,
  input wire logic comp_power_down_o,
  input wire logic pin_change_block_o,
  input wire logic neg_use_mux_o,
  input wire logic conv_enable_o,
  input wire logic conv_busy_o
);
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_one;
    s_take |=> s_pulse;
  endproperty
  property p_dat_hi;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  property p_comp_gate;
    !global_irq_enable_i |=> !comp_irq_o;
  endproperty
  property p_conv_gate;
    !global_irq_enable_i |=> !conv_irq_o;
  endproperty
  property p_pin_block;
    $stable(comp_power_down_o) [*3] |-> pin_change_block_o == !comp_power_down_o;
  endproperty
  property p_mux_off;
    conv_enable_o [*3] |-> !neg_use_mux_o;
  endproperty
  property p_busy_off;
    !conv_enable_o [*2] |-> !conv_busy_o;
  endproperty
  property p_busy_en;
    $rose(conv_busy_o) |-> conv_enable_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not a single pulse");
  a_dat_hi: assert property (p_dat_hi) else $error("read data upper bits set");
  a_comp_gate: assert property (p_comp_gate) else $error("comparator irq ungated");
  a_conv_gate: assert property (p_conv_gate) else $error("converter irq ungated");
  a_pin_block: assert property (p_pin_block) else $error("pin change block wrong");
  a_mux_off: assert property (p_mux_off) else $error("mux used while converter on");
  a_busy_off: assert property (p_busy_off) else $error("busy while disabled");
  a_busy_en: assert property (p_busy_en) else $error("conversion began disabled");
endmodule
bind cadc_top cadc_sva cadc_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .global_irq_enable_i, .comp_irq_o, .conv_irq_o, .comp_power_down_o, .pin_change_block_o,
  .neg_use_mux_o, .conv_enable_o, .conv_busy_o);

// ### testbench/cadc_top_tb.sv
// Self-checking bench for the comparator and converter control block
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module cadc_top_tb
  import cadc_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, global_irq_enable_i;
  logic comp_vector_ack_i, conv_vector_ack_i, comp_irq_o, conv_irq_o, comp_raw_i;
  logic comp_power_down_o, bandgap_select_o, neg_use_mux_o, pin_change_block_o;
  logic conv_enable_o, conv_busy_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, neg_channel_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [9:0] conv_sample_i;
  logic [4:0] conv_channel_o;
  logic [1:0] conv_ref_o;
  int n_errors = 0;
  int checks_done = 0;
  int busy_cyc = 0;
  int b0;
  cadc_top cadc_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .global_irq_enable_i, .comp_vector_ack_i,
    .conv_vector_ack_i, .comp_irq_o, .conv_irq_o, .comp_raw_i, .comp_power_down_o,
    .bandgap_select_o, .neg_use_mux_o, .neg_channel_o, .pin_change_block_o, .conv_sample_i,
    .conv_enable_o, .conv_busy_o, .conv_channel_o, .conv_ref_o);

  ////////////////////////////////////////////////////////////////////////////
  // Clock, busy counter, watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (conv_busy_o === 1'b1) busy_cyc <= busy_cyc + 1;
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(a, 1'b0, 8'h00, q);
    `CHK(nm, e, q)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_done();
    logic [7:0] q;
    int n;
    n = 0;
    do
    begin
      wb(CADC_ADDR_CONV_CTRL, 1'b0, 8'h00, q);
      n++;
    end
    while (q[CADC_CONV_START_BIT] !== 1'b0 && n < 100);
    `CHK("done_wait", 1'b0, q[CADC_CONV_START_BIT])
  endtask
  task automatic close_out();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, global_irq_enable_i} = 5'b10000;
    {comp_vector_ack_i, conv_vector_ack_i, comp_raw_i} = 3'b000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    conv_sample_i = 10'h2C5;
    tick(6);
    rst_i <= 1'b0;
    rd(CADC_ADDR_CMP_CTRL, 8'h00, "cmp_rst");
    rd(CADC_ADDR_CHAN_SEL, 8'h00, "chan_rst");
    rd(CADC_ADDR_CONV_CTRL, 8'h00, "conv_rst");
    rd(8'h14, 8'h00, "unmapped");
    wr(CADC_ADDR_CMP_CTRL, 8'h04);
    wr(CADC_ADDR_CHAN_SEL, 8'h1A);
    tick(3);
    `CHK("mux_on", 1'b1, neg_use_mux_o)
    `CHK("neg_chan", 4'hA, neg_channel_o)
    `CHK("pin_block", 1'b1, pin_change_block_o)
    for (int m = 0; m < 4; m++)
    begin
      wr(CADC_ADDR_CMP_CTRL, 8'h10 | m[7:0]);
      @(posedge clk_i);
      comp_raw_i <= 1'b1;
      tick(6);
      rd(CADC_ADDR_CMP_CTRL, {2'b00, 1'b1, m != 1 && m != 2, 2'b00, m[1:0]}, "rise");
      wr(CADC_ADDR_CMP_CTRL, 8'h10 | m[7:0]);
      @(posedge clk_i);
      comp_raw_i <= 1'b0;
      tick(6);
      rd(CADC_ADDR_CMP_CTRL, {3'b000, m == 0 || m == 2, 2'b00, m[1:0]}, "fall");
    end
    wr(CADC_ADDR_CMP_CTRL, 8'h08);
    global_irq_enable_i <= 1'b1;
    comp_raw_i <= 1'b1;
    tick(6);
    `CHK("comp_irq", 1'b1, comp_irq_o)
    comp_vector_ack_i <= 1'b1;
    tick(1);
    comp_vector_ack_i <= 1'b0;
    tick(2);
    `CHK("comp_irq_clr", 1'b0, comp_irq_o)
    wr(CADC_ADDR_CMP_CTRL, 8'h00);
    wr(CADC_ADDR_CMP_CTRL, 8'hC4);
    tick(3);
    `CHK("power_down", 1'b1, comp_power_down_o)
    `CHK("bandgap", 1'b1, bandgap_select_o)
    `CHK("pin_free", 1'b0, pin_change_block_o)
    `CHK("mux_idle", 1'b1, neg_use_mux_o)
    wr(CADC_ADDR_CHAN_SEL, 8'h00);
    wr(CADC_ADDR_CONV_CTRL, 8'h88);
    b0 = busy_cyc;
    wr(CADC_ADDR_CONV_CTRL, 8'hC8);
    rd(CADC_ADDR_CONV_CTRL, 8'hC8, "start_busy");
    `CHK("mux_off", 1'b0, neg_use_mux_o)
    `CHK("conv_on", 1'b1, conv_enable_o)
    wait_done();
    `CHK("first_len", 1'b1, (busy_cyc - b0) inside {[49:54]})
    rd(CADC_ADDR_CONV_CTRL, 8'h98, "done");
    `CHK("conv_irq", 1'b1, conv_irq_o)
    rd(CADC_ADDR_RES_LOW, 8'hC5, "right_low");
    rd(CADC_ADDR_RES_HIGH, 8'h02, "right_high");
    wr(CADC_ADDR_CHAN_SEL, 8'h20);
    rd(CADC_ADDR_RES_LOW, 8'h40, "left_low");
    rd(CADC_ADDR_RES_HIGH, 8'hB1, "left_high");
    rd(CADC_ADDR_RES_LOW, 8'h40, "lock_low");
    conv_sample_i <= 10'h1FF;
    b0 = busy_cyc;
    wr(CADC_ADDR_CONV_CTRL, 8'hD8);
    wait_done();
    `CHK("norm_len", 1'b1, (busy_cyc - b0) inside {[25:30]})
    rd(CADC_ADDR_RES_HIGH, 8'hB1, "lock_high");
    rd(CADC_ADDR_CONV_CTRL, 8'h98, "lost_done");
    wr(CADC_ADDR_CONV_CTRL, 8'hD8);
    wr(CADC_ADDR_CHAN_SEL, 8'h67);
    `CHK("chan_held", 5'h00, conv_channel_o)
    wait_done();
    `CHK("chan_new", 5'h07, conv_channel_o)
    `CHK("ref_new", 2'h1, conv_ref_o)
    rd(CADC_ADDR_RES_LOW, 8'hC0, "new_low");
    rd(CADC_ADDR_RES_HIGH, 8'h7F, "new_high");
    conv_sample_i <= 10'h155;
    wr(CADC_ADDR_CONV_CTRL, 8'hF8);
    tick(60);
    rd(CADC_ADDR_CONV_CTRL, 8'hF8, "free_run");
    `CHK("free_busy", 1'b1, conv_busy_o)
    rd(CADC_ADDR_RES_LOW, 8'h40, "free_low");
    rd(CADC_ADDR_RES_HIGH, 8'h55, "free_high");
    wr(CADC_ADDR_CONV_CTRL, 8'h00);
    tick(3);
    `CHK("conv_off", 1'b0, conv_busy_o)
    `CHK("conv_dis", 1'b0, conv_enable_o)
    rd(CADC_ADDR_CONV_CTRL, 8'h10, "off_status");
    close_out();
  end
endmodule

// ### verilog/cadc_top.sv
// Comparator and successive-approximation converter control logic
//
// How it works
// - Output bit reflects positive above negative input
// - Disable bit seven powers comparator off
// - Bandgap bit six routes reference to positive
// - Flag on matching event; request needs enables
// - Flag cleared by vector or written one
// - Interrupt enable bit three gates request
// - Mode bits: toggle, falling, rising; 01 reserved
// - Mux enable, converter off: channel picks negative
// - Otherwise dedicated negative pin drives negative
// - Negative selection applies one cycle after write
// - Enabled comparator blocks both pin-change interrupts
// - Single or free-running conversion mode
// - Converter idle and unapplied while disabled
// - Start bit reads one until completion
// - Channel change waits for running conversion
// - Ten-bit result, right or left aligned
// - Low read locks results until high read
// - Done interrupt raised even when result discarded
// - Normal 13 cycles, first after enable 25
// - Completion writes result unless locked, sets flag, clears start if single
// - Free-running restarts at once, start stays set
`timescale 1ns/10ps
module cadc_top
  import cadc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor side
  input wire logic global_irq_enable_i,
  input wire logic comp_vector_ack_i,
  input wire logic conv_vector_ack_i,
  output logic comp_irq_o,
  output logic conv_irq_o,
  // Analog comparator
  input wire logic comp_raw_i,
  output logic comp_power_down_o,
  output logic bandgap_select_o,
  output logic neg_use_mux_o,
  output logic [3:0] neg_channel_o,
  output logic pin_change_block_o,
  // Analog converter
  input wire logic [9:0] conv_sample_i,
  output logic conv_enable_o,
  output logic conv_busy_o,
  output logic [4:0] conv_channel_o,
  output logic [1:0] conv_ref_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] cmp_ctrl_q;
  logic [7:0] chan_sel_q;
  logic [7:0] conv_ctrl_q;
  logic cmp_flag_q;
  logic conv_start_q;
  logic conv_done_q;
  logic [9:0] result_q;
  logic lock_q;
  logic ack_q;
  logic [31:0] rdata_q;

  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  logic conv_en;
  assign conv_en = conv_ctrl_q[CADC_CONV_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser and edge detection
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic cmp_event;
  cadc_mode_type mode;
  assign mode = cadc_mode_type'(cmp_ctrl_q[CADC_CMP_MODE_HI_BIT:CADC_CMP_MODE_LO_BIT]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= comp_raw_i & ~cmp_ctrl_q[CADC_CMP_DISABLE_BIT];
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_comb
  begin
    cmp_event = 1'b0;
    unique case (mode)
      CADC_MODE_TOGGLE: cmp_event = sync2_q ^ sync3_q;
      CADC_MODE_RESERVED: cmp_event = 1'b0;
      CADC_MODE_FALL: cmp_event = ~sync2_q & sync3_q;
      CADC_MODE_RISE: cmp_event = sync2_q & ~sync3_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator control register and flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_ctrl_q <= CADC_CMP_CTRL_RESET;
    else if (wr && wb_adr_i == CADC_ADDR_CMP_CTRL)
    begin
      cmp_ctrl_q <= wbyte & 8'hCF;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_flag_q <= 1'b0;
    else if (cmp_event)
      cmp_flag_q <= 1'b1;
    else if (comp_vector_ack_i)
      cmp_flag_q <= 1'b0;
    else if (wr && wb_adr_i == CADC_ADDR_CMP_CTRL && wbyte[CADC_CMP_FLAG_BIT])
      cmp_flag_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel select register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chan_sel_q <= CADC_CHAN_SEL_RESET;
    else if (wr && wb_adr_i == CADC_ADDR_CHAN_SEL)
      chan_sel_q <= wbyte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comp_power_down_o <= 1'b0;
      bandgap_select_o <= 1'b0;
      neg_use_mux_o <= 1'b0;
      neg_channel_o <= 4'h0;
      pin_change_block_o <= 1'b0;
      comp_irq_o <= 1'b0;
    end
    else
    begin
      comp_power_down_o <= cmp_ctrl_q[CADC_CMP_DISABLE_BIT];
      bandgap_select_o <= cmp_ctrl_q[CADC_CMP_BANDGAP_BIT];
      neg_use_mux_o <= cmp_ctrl_q[CADC_CMP_MUX_EN_BIT] & ~conv_en;
      neg_channel_o <= chan_sel_q[3:0];
      pin_change_block_o <= ~cmp_ctrl_q[CADC_CMP_DISABLE_BIT];
      comp_irq_o <= cmp_flag_q & cmp_ctrl_q[CADC_CMP_IRQ_EN_BIT]
                    & global_irq_enable_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock prescaler
  logic [8:0] ps_cnt_q;
  logic [8:0] ps_div;
  logic tick;
  assign ps_div = CADC_PRESCALE_BASE << conv_ctrl_q[CADC_CONV_PS_HI_BIT:0];
  assign tick = conv_en && (ps_cnt_q == ps_div - 9'h001);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !conv_en || tick)
      ps_cnt_q <= 9'h000;
    else
      ps_cnt_q <= ps_cnt_q + 9'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  cadc_state_type state_q;
  logic [4:0] cyc_cnt_q;
  logic first_q;
  logic done_now;
  logic [4:0] conv_len;
  assign conv_len = first_q ? CADC_EXTENDED_CYCLES : CADC_NORMAL_CYCLES;
  assign done_now = (state_q == CADC_RUN) && tick && (cyc_cnt_q == conv_len - 5'd1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !conv_en)
    begin
      state_q <= CADC_IDLE;
      cyc_cnt_q <= 5'd0;
    end
    else
    begin
      unique case (state_q)
        CADC_IDLE:
        begin
          if (conv_start_q && tick)
          begin
            state_q <= CADC_RUN;
            cyc_cnt_q <= 5'd0;
          end
        end
        CADC_RUN:
        begin
          if (done_now)
          begin
            cyc_cnt_q <= 5'd0;
            if (!conv_ctrl_q[CADC_CONV_FREE_BIT])
              state_q <= CADC_IDLE;
          end
          else if (tick)
            cyc_cnt_q <= cyc_cnt_q + 5'd1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !conv_en)
      first_q <= 1'b1;
    else if (done_now)
      first_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter control register, start and done
  logic conv_wr;
  assign conv_wr = wr && wb_adr_i == CADC_ADDR_CONV_CTRL;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      conv_ctrl_q <= CADC_CONV_CTRL_RESET;
    else if (conv_wr)
      conv_ctrl_q <= wbyte & 8'hAF;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      conv_start_q <= 1'b0;
    else if (conv_wr && !wbyte[CADC_CONV_ENABLE_BIT])
      conv_start_q <= 1'b0;
    else if (conv_wr && wbyte[CADC_CONV_START_BIT])
      conv_start_q <= 1'b1;
    else if (!conv_en)
      conv_start_q <= 1'b0;
    else if (done_now && !conv_ctrl_q[CADC_CONV_FREE_BIT])
      conv_start_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      conv_done_q <= 1'b0;
    else if (done_now)
      conv_done_q <= 1'b1;
    else if (conv_vector_ack_i)
      conv_done_q <= 1'b0;
    else if (conv_wr && wbyte[CADC_CONV_DONE_BIT])
      conv_done_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result register and read lock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_q <= 10'h000;
    else if (done_now && !lock_q)
      result_q <= conv_sample_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lock_q <= 1'b0;
    else if (rd && wb_adr_i == CADC_ADDR_RES_HIGH)
      lock_q <= 1'b0;
    else if (rd && wb_adr_i == CADC_ADDR_RES_LOW)
      lock_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_enable_o <= 1'b0;
      conv_busy_o <= 1'b0;
      conv_channel_o <= 5'h00;
      conv_ref_o <= 2'h0;
      conv_irq_o <= 1'b0;
    end
    else
    begin
      conv_enable_o <= conv_en;
      conv_busy_o <= (state_q == CADC_RUN);
      if (conv_en && (state_q == CADC_IDLE || done_now))
      begin
        conv_channel_o <= chan_sel_q[CADC_CHAN_TOP_BIT:0];
        conv_ref_o <= chan_sel_q[CADC_CHAN_REF_HI_BIT:CADC_CHAN_REF_LO_BIT];
      end
      conv_irq_o <= conv_done_q & conv_ctrl_q[CADC_CONV_IRQ_EN_BIT]
                    & global_irq_enable_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge
  logic [7:0] rbyte;
  logic left;
  assign left = chan_sel_q[CADC_CHAN_LEFT_BIT];

  always_comb
  begin
    rbyte = 8'h00;
    unique case (wb_adr_i)
      CADC_ADDR_CMP_CTRL:
      begin
        rbyte = cmp_ctrl_q;
        rbyte[CADC_CMP_OUTPUT_BIT] = sync3_q;
        rbyte[CADC_CMP_FLAG_BIT] = cmp_flag_q;
      end
      CADC_ADDR_CHAN_SEL: rbyte = chan_sel_q;
      CADC_ADDR_CONV_CTRL:
      begin
        rbyte = conv_ctrl_q;
        rbyte[CADC_CONV_START_BIT] = conv_start_q;
        rbyte[CADC_CONV_DONE_BIT] = conv_done_q;
      end
      CADC_ADDR_RES_LOW: rbyte = left ? {result_q[1:0], 6'h00} : result_q[7:0];
      CADC_ADDR_RES_HIGH: rbyte = left ? result_q[9:2] : {6'h00, result_q[9:8]};
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= acc;
      if (rd)
        rdata_q <= {24'h00_0000, rbyte};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule
